// *** rtl/prog_port.sv ***
// Serial programming and one-time verify port of the configuration array
//
// Overview of operation
// - Store complete 192-bit image in nonvolatile array
// - Mode entry clears every array location to zero
// - Sixteen-bit words, device samples data on clocks
// - Verify clocks drive stored bits onto data line
// - No read-back without a complete programming cycle
// - Verify only once, right after programming
`timescale 1ns/1ps
`default_nettype none

module prog_port
  import prog_port_pkg::*;
#(
  parameter int WORD_W    = WORD_BITS,
  parameter int WORDS     = IMAGE_WORDS,
  parameter int SETUP_MIN = SETUP_MIN_CYC,
  parameter int SETUP_MAX = SETUP_MAX_CYC,
  parameter int ERASE     = ERASE_CYC,
  parameter int WRITE     = WRITE_CYC
) (
  // System
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic                       clk_en,
  // Programming pins
  input  wire logic                       button_input_two,
  input  wire logic                       data_in,
  output logic                            data_out,
  output logic                            data_oe,
  // Encoder core read port
  input  wire logic [$clog2(WORDS)-1:0]   cfg_addr,
  output logic      [WORD_W-1:0]          cfg_word,
  // Status
  output logic                            prog_active,
  output logic                            verify_active,
  output logic                            image_loaded
);

  localparam int ADDR_W = $clog2(WORDS);
  localparam int IDX_W  = $clog2(WORDS + 1);
  localparam int BIT_W  = $clog2(WORD_W);
  localparam int RD_W   = $clog2(WORDS * WORD_W + 1);

  typedef enum logic [2:0] {st_idle, st_erase, st_load, st_drain, st_verify} port_state_e;

  port_state_e       state;
  port_state_e       next_state;
  logic              btn_s1, btn_s2, btn_d;
  logic              dat_s1, dat_s2, dat_d;
  logic              btn_rise, btn_fall, dat_rise, enter;
  logic [CNT_W-1:0]  hold_cnt;
  logic [CNT_W-1:0]  erase_cnt;
  logic [CNT_W-1:0]  write_cnt;
  logic [WORD_W-1:0] shift;
  logic [BIT_W-1:0]  bit_cnt;
  logic [IDX_W-1:0]  push_cnt;
  logic [IDX_W-1:0]  wr_idx;
  logic [RD_W-1:0]   rd_cnt;
  logic              word_pend;
  logic              in_ready, out_valid, out_ready, out_fire;
  logic [WORD_W-1:0] out_word;
  logic [WORD_W-1:0] mem [WORDS];
  logic              rd_bit;

  // Low-to-high change seen between two sampled copies
  function automatic logic rose(input logic now, input logic prev);
    rose = now && !prev;
  endfunction : rose

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Both pins are asynchronous; clock phases of 50 us span many samples
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      btn_s1 <= 1'b0;
      btn_s2 <= 1'b0;
      btn_d  <= 1'b0;
      dat_s1 <= 1'b0;
      dat_s2 <= 1'b0;
      dat_d  <= 1'b0;
    end else if (clk_en) begin
      btn_s1 <= button_input_two;
      btn_s2 <= btn_s1;
      btn_d  <= btn_s2;
      dat_s1 <= data_in;
      dat_s2 <= dat_s1;
      dat_d  <= dat_s2;
    end
  end

  assign btn_rise = rose(btn_s2, btn_d);
  assign btn_fall = rose(btn_d, btn_s2);
  assign dat_rise = rose(dat_s2, dat_d);

  // ----------------------------------------------------------------
  // Mode entry and sequencing
  // ----------------------------------------------------------------
  // Button high time, saturating just past the window
  always_ff @(posedge clk_sys) begin
    if (!nrst) hold_cnt <= '0;
    else if (clk_en) begin
      if (!btn_s2) hold_cnt <= '0;
      else if (hold_cnt <= CNT_W'(SETUP_MAX)) hold_cnt <= CNT_W'(hold_cnt + 1'b1);
    end
  end

  // Data rising only counts after a setup hold inside the window
  assign enter = (state == st_idle) && dat_rise &&
                 (hold_cnt >= CNT_W'(SETUP_MIN)) && (hold_cnt <= CNT_W'(SETUP_MAX));

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      st_idle:   if (enter) next_state = st_erase;
      st_erase:  if (erase_cnt == CNT_W'(ERASE - 1)) next_state = st_load;
      st_load:   if (push_cnt == IDX_W'(WORDS) && !word_pend) next_state = st_drain;
      st_drain:  if (!out_valid && write_cnt == '0) next_state = st_verify;
      st_verify: if (btn_fall && rd_cnt == RD_W'(WORDS * WORD_W)) next_state = st_idle;
      default:   next_state = st_idle;
    endcase
  end

  // State and registered status flags
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state         <= st_idle;
      prog_active   <= 1'b0;
      verify_active <= 1'b0;
    end else if (clk_en) begin
      state         <= next_state;
      prog_active   <= (next_state != st_idle);
      verify_active <= (next_state == st_verify);
    end
  end

  // Bulk write time; clocks arriving meanwhile are ignored
  always_ff @(posedge clk_sys) begin
    if (!nrst) erase_cnt <= '0;
    else if (clk_en) begin
      if (state == st_erase) erase_cnt <= CNT_W'(erase_cnt + 1'b1);
      else erase_cnt <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Serial word loader
  // ----------------------------------------------------------------
  // Least significant bit first; a finished word waits for buffer room
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      shift     <= WORD_RESET;
      bit_cnt   <= '0;
      push_cnt  <= '0;
      word_pend <= 1'b0;
    end else if (clk_en) begin
      if (enter) begin
        bit_cnt   <= '0;
        push_cnt  <= '0;
        word_pend <= 1'b0;
      end else begin
        if (word_pend && in_ready) word_pend <= 1'b0;
        if (state == st_load && btn_rise && !word_pend && push_cnt != IDX_W'(WORDS)) begin
          shift   <= {dat_s2, shift[WORD_W-1:1]};
          bit_cnt <= BIT_W'(bit_cnt + 1'b1);
          if (bit_cnt == BIT_W'(WORD_W - 1)) begin
            word_pend <= 1'b1;
            push_cnt  <= IDX_W'(push_cnt + 1'b1);
          end
        end
      end
    end
  end

  word_buffer #(
    .WIDTH (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_buffer (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .in_valid  (word_pend),
    .in_ready  (in_ready),
    .in_word   (shift),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_word  (out_word)
  );

  // ----------------------------------------------------------------
  // Array writer
  // ----------------------------------------------------------------
  // One word per write cycle; a busy writer stalls the buffer
  assign out_ready = (state == st_load || state == st_drain) && (write_cnt == '0);
  assign out_fire  = out_valid && out_ready && clk_en;

  always_ff @(posedge clk_sys) begin
    if (!nrst) write_cnt <= '0;
    else if (clk_en) begin
      if (out_fire) write_cnt <= CNT_W'(WRITE - 1);
      else if (write_cnt != '0) write_cnt <= CNT_W'(write_cnt - 1'b1);
    end
  end

  // Array contents survive reset, as nonvolatile cells would
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (enter) begin
        for (int i = 0; i < WORDS; i++) mem[i] <= WORD_RESET;
      end else if (out_fire) begin
        mem[ADDR_W'(wr_idx)] <= out_word;
      end
    end
  end

  // Write index and completed-image flag
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wr_idx       <= '0;
      image_loaded <= 1'b0;
    end else if (clk_en) begin
      if (enter) begin
        wr_idx       <= '0;
        image_loaded <= 1'b0;
      end else if (out_fire) begin
        wr_idx       <= IDX_W'(wr_idx + 1'b1);
        image_loaded <= (wr_idx == IDX_W'(WORDS - 1));
      end
    end
  end

  // Registered read port toward the encoder core
  always_ff @(posedge clk_sys) begin
    if (!nrst) cfg_word <= WORD_RESET;
    else if (clk_en) cfg_word <= (cfg_addr < ADDR_W'(WORDS)) ? mem[cfg_addr] : WORD_RESET;
  end

  // ----------------------------------------------------------------
  // One-time verify
  // ----------------------------------------------------------------
  assign rd_bit = (rd_cnt < RD_W'(WORDS * WORD_W)) ?
                  mem[ADDR_W'(rd_cnt / RD_W'(WORD_W))][BIT_W'(rd_cnt % RD_W'(WORD_W))] : 1'b0;

  // The line is driven only inside the verify state, never otherwise
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_cnt   <= '0;
      data_out <= 1'b0;
      data_oe  <= 1'b0;
    end else if (clk_en) begin
      if (next_state != st_verify) begin
        rd_cnt   <= '0;
        data_out <= 1'b0;
        data_oe  <= 1'b0;
      end else if (state == st_verify && btn_rise && rd_cnt != RD_W'(WORDS * WORD_W)) begin
        rd_cnt   <= RD_W'(rd_cnt + 1'b1);
        data_out <= rd_bit;
        data_oe  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [1:0]        verify_entries;
  logic [WORD_W-1:0] mem_or;

  // Entries into verify since the last erase
  always_ff @(posedge clk_sys) begin
    if (!nrst || state == st_erase) verify_entries <= '0;
    else if (clk_en && state != st_verify && next_state == st_verify && verify_entries != 2'h3)
      verify_entries <= 2'(verify_entries + 1'b1);
  end

  always_comb begin
    mem_or = '0;
    for (int i = 0; i < WORDS; i++) mem_or = mem_or | mem[i];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_load_edge;
    state == st_load && clk_en && btn_rise && !word_pend && push_cnt != IDX_W'(WORDS);
  endsequence
  sequence s_verify_edge;
    state == st_verify && clk_en && btn_rise && rd_cnt != RD_W'(WORDS * WORD_W);
  endsequence

  a_bit_shift: assert property (s_load_edge |=> shift[WORD_W-1] == $past(dat_s2) &&
                                bit_cnt == BIT_W'($past(bit_cnt) + 1'b1))
    else $error("serial bit not captured");
  a_word_store: assert property (out_fire |=> mem[ADDR_W'($past(wr_idx))] == $past(out_word))
    else $error("word not written to array");
  a_erase_zero: assert property (state == st_erase |-> mem_or == '0)
    else $error("array not cleared on entry");
  a_verify_bit: assert property (s_verify_edge |=> data_oe && data_out == $past(rd_bit))
    else $error("verify bit not driven");
  a_verify_gate: assert property ($rose(state == st_verify) |-> $past(wr_idx) == IDX_W'(WORDS))
    else $error("verify without full image");
  a_line_quiet: assert property (state != st_verify && $past(state) != st_verify |-> !data_oe)
    else $error("data line driven outside verify");
  a_verify_once: assert property (verify_entries <= 2'h1)
    else $error("second verify allowed");

endmodule : prog_port

`default_nettype wire

// *** pkg/prog_port_pkg.sv ***
// Constants shared by the configuration programming port
`default_nettype none

package prog_port_pkg;

  // ----------------------------------------------------------------
  // Image layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS   = 16;
  localparam int IMAGE_BITS  = 192;
  localparam int IMAGE_WORDS = IMAGE_BITS / WORD_BITS;
  localparam int BUF_DEPTH   = 2;
  localparam int CNT_W       = 24;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Timing, as printed, and derived cycle counts
  // ----------------------------------------------------------------
  localparam real CLK_FREQ_MHZ    = 25.0;
  localparam real SETUP_MIN_MS    = 3.5;
  localparam real SETUP_MAX_MS    = 4.5;
  localparam real ERASE_WAIT_MS   = 4.0;
  localparam real WRITE_CYCLE_MS  = 50.0;

  // Least times round up, longest times round down
  localparam int SETUP_MIN_CYC = int'($ceil(SETUP_MIN_MS * 1000.0 * CLK_FREQ_MHZ));
  localparam int SETUP_MAX_CYC = int'($floor(SETUP_MAX_MS * 1000.0 * CLK_FREQ_MHZ));
  localparam int ERASE_CYC     = int'($floor(ERASE_WAIT_MS * 1000.0 * CLK_FREQ_MHZ));
  localparam int WRITE_CYC     = int'($floor(WRITE_CYCLE_MS * 1000.0 * CLK_FREQ_MHZ));

endpackage : prog_port_pkg

`default_nettype wire

// *** rtl/word_buffer.sv ***
// Small valid/ready word buffer between serial loader and array writer
`timescale 1ns/1ps
`default_nettype none

module word_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // System
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             clk_en,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_word,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_word
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] slot [DEPTH];
  logic [PTR_W-1:0] wptr;
  logic [PTR_W-1:0] rptr;
  logic [CNT_W-1:0] fill;
  logic             push;
  logic             pop;

  // Wrap a pointer at the buffer depth
  function automatic logic [PTR_W-1:0] advance(input logic [PTR_W-1:0] p);
    advance = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction : advance

  // Full and empty come from the fill count only
  assign in_ready  = (fill != CNT_W'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_word  = slot[rptr];
  assign push      = in_valid && in_ready && clk_en;
  assign pop       = out_valid && out_ready && clk_en;

  // Pointers and fill level
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wptr <= '0;
      rptr <= '0;
      fill <= '0;
    end else begin
      if (push) wptr <= advance(wptr);
      if (pop) rptr <= advance(rptr);
      if (push && !pop) fill <= CNT_W'(fill + 1'b1);
      else if (pop && !push) fill <= CNT_W'(fill - 1'b1);
    end
  end

  // Storage needs no reset; reads are gated by out_valid
  always_ff @(posedge clk_sys) begin
    if (push) slot[wptr] <= in_word;
  end

endmodule : word_buffer

`default_nettype wire

// *** sim/prog_model.sv ***
// Behavioural production programmer on the link pins
`timescale 1ns/1ps
`default_nettype none

module prog_model #(
  parameter int ERASE_WAIT = 40
) (
  // System
  input  wire logic clk_sys,
  // Link pins
  output logic      button,
  output logic      drv_data,
  output logic      drv_oe,
  input  wire logic line
);
  // Pins idle; data left to the pull-down, never pulled high
  initial begin
    button   = 1'b0;
    drv_data = 1'b0;
    drv_oe   = 1'b0;
  end

  // Park clock low and release the data line
  task automatic idle(input int n);
    button   <= 1'b0;
    drv_data <= 1'b0;
    drv_oe   <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask : idle

  // Setup hold, data rise, then bulk write wait
  task automatic enter(input int hold);
    button <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    drv_oe   <= 1'b1;
    drv_data <= 1'b1;
    repeat (6) @(posedge clk_sys);
    idle(ERASE_WAIT);
  endtask : enter

  // Period of 8 cycles, low 3 high 5; line read late in high phase
  task automatic clock_bit(input logic d, output logic q);
    drv_data <= d;
    button   <= 1'b0;
    repeat (3) @(posedge clk_sys);
    button <= 1'b1;
    repeat (5) @(posedge clk_sys);
    q = line;
  endtask : clock_bit

  // Sixteen bits LSB first, then the write pause when asked
  task automatic send_word(input logic [15:0] w, input int gap);
    logic q;
    drv_oe <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      clock_bit(w[i], q);
    end
    if (gap > 0) begin
      idle(gap);
    end
  endtask : send_word
endmodule : prog_model

`default_nettype wire

// *** sim/tb_prog_port.sv ***
// Self-checking bench for the programming port
`timescale 1ns/1ps
`default_nettype none

module tb_prog_port;
  import prog_port_pkg::*;
  localparam int WRITE_T = 300;
  localparam int ERASE_T = 30;

  logic        clk_sys;
  logic        nrst;
  logic        clk_en;
  logic [3:0]  cfg_addr;
  logic [15:0] cfg_word;
  logic        data_out;
  logic        data_oe;
  logic        prog_active;
  logic        verify_active;
  logic        image_loaded;
  logic        button;
  logic        drv_data;
  logic        drv_oe;
  wire logic   line;
  logic [15:0] img [12];
  int          err_total;
  int          samples_checked;

  // ----------------------------------------------------------------
  // Wiring
  // ----------------------------------------------------------------
  // Pull-down wins only when nobody drives
  assign line = data_oe ? data_out : (drv_oe ? drv_data : 1'b0);

  // Long counts shortened; write time kept above a word so one word waits in the buffer
  prog_port #(.SETUP_MIN(20), .SETUP_MAX(40), .ERASE(ERASE_T), .WRITE(WRITE_T)) u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en),
    .button_input_two(button), .data_in(line), .data_out(data_out), .data_oe(data_oe),
    .cfg_addr(cfg_addr), .cfg_word(cfg_word),
    .prog_active(prog_active), .verify_active(verify_active), .image_loaded(image_loaded)
  );

  // Model's default bulk write wait already sits ten cycles past ERASE_T
  prog_model u_prog (
    .clk_sys(clk_sys), .button(button), .drv_data(drv_data), .drv_oe(drv_oe), .line(line)
  );

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Read port sweep; registered one cycle after the index
  task automatic sweep(input logic zero);
    for (int k = 0; k < 12; k++) begin
      cfg_addr <= 4'(k);
      repeat (2) @(posedge clk_sys);
      check(cfg_word, zero ? 16'h0000 : img[k]);
    end
  endtask : sweep

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check({10'h0, cfg_word[5:0] | cfg_word[15:10], data_oe}, 16'h0000);
    check({13'h0, prog_active, verify_active, image_loaded}, 16'h0000);
  endtask : t_reset

  // Read-back and bad entries before any programming
  task automatic t_refused();
    logic q;
    for (int i = 0; i < 16; i++) begin
      u_prog.clock_bit(1'b1, q);
      check({14'h0, data_oe, q}, 16'h0000);
    end
    u_prog.idle(4);
    u_prog.enter(12);
    check({15'h0, prog_active}, 16'h0000);
    u_prog.enter(70);
    check({15'h0, prog_active}, 16'h0000);
  endtask : t_refused

  // Entry, erase, then words in back-to-back pairs so the second waits in the buffer
  task automatic t_program();
    u_prog.enter(30);
    check({14'h0, prog_active, verify_active}, 16'h0002);
    sweep(1'b1);
    for (int p = 0; p < 6; p++) begin
      u_prog.send_word(img[2*p], 0);
      u_prog.send_word(img[2*p+1], 2*WRITE_T + 40);
    end
    check({14'h0, image_loaded, verify_active}, 16'h0003);
    sweep(1'b0);
    t_freeze();
  endtask : t_program

  // Clock enable low freezes state, status and the read port
  task automatic t_freeze();
    clk_en   <= 1'b0;
    cfg_addr <= 4'h5;
    repeat (20) @(posedge clk_sys);
    check({13'h0, prog_active, verify_active, image_loaded}, 16'h0007);
    check(cfg_word, img[11]);
    clk_en <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check(cfg_word, img[5]);
  endtask : t_freeze

  // One read-back of all 192 bits in load order, then back to idle
  task automatic t_verify();
    logic q;
    for (int n = 0; n < 192; n++) begin
      u_prog.clock_bit(1'b0, q);
      check({14'h0, data_oe, q}, {14'h0, 1'b1, img[n/16][n%16]});
    end
    u_prog.idle(8);
    check({13'h0, data_oe, prog_active, verify_active}, 16'h0000);
  endtask : t_verify

  // A second read-back must find the line undriven
  task automatic t_second();
    logic q;
    for (int i = 0; i < 16; i++) begin
      u_prog.clock_bit(1'b1, q);
      check({14'h0, data_oe, q}, 16'h0000);
    end
  endtask : t_second

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    err_total       = 0;
    samples_checked = 0;
    nrst            = 1'b0;
    clk_en          = 1'b1;
    cfg_addr        = 4'h0;
    for (int k = 0; k < 12; k++) begin
      img[k] = 16'hC35A + 16'(k) * 16'h1F0D;
    end
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_refused();
    t_program();
    t_verify();
    t_second();
    print_verdict();
  end

  // Whole run needs about 7500 cycles; a hang ends well past that
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    print_verdict();
  end
endmodule : tb_prog_port

`default_nettype wire
